// ---- hdl/hfp_host_ports.sv ----
// Contract
// - writes to a read-only register change nothing in the device
// - reads of a write-only register return all zeros
// - write-one-clear bit: writing 1 clears, 0 leaves, stays readable
// - clear-on-read bit is cleared by the host reading it
// - latch bits hold their latched condition until the register is read
// - keep-on-soft-reset fields survive a software reset
// - a full reset loads defaults into all registers but FIFO storage; a soft reset spares keepField, txLow, lvlSync, lvl, hostRdata and hostRvalid
// - four host FIFOs; data and rx status sizes set by a control register
// - rx status main port read returns oldest entry and pops it
// - rx status peek read returns oldest entry without popping
// - rx data FIFO is read-only; each 32-bit read pops the oldest word, a 16-bit host pops only on the upper-half read
// - rx data port is aliased over 8 dwords or 16 words
// - tx status main port read returns oldest entry and pops it
// - tx status peek read returns oldest entry, FIFO unchanged
// - tx data FIFO is write-only; each 32-bit write appends one word, a 16-bit host appends only on the upper-half write
// - tx data port is aliased over 8 dwords or 16 words
`timescale 1ns/1ns
`include "hfp_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module hfp_fifo #(
    parameter int DW = 32,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    // fill side
    input wire logic push,
    input wire logic [DW-1:0] din,
    output logic ready,
    // drain side
    input wire logic pop,
    input wire logic [7:0] limit,
    output logic [DW-1:0] head,
    output logic [CW-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic doPush;
    logic doPop;
    logic [CW-1:0] next_count;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign doPush = push && ready;
    assign doPop = pop && (count != '0);
    assign head = mem[rdPtr];

    always_comb begin
        next_count = count;
        if (doPush && !doPop) begin
            next_count = count + 1'b1;
        end else if (doPop && !doPush) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            ready <= 1'b0;
        end else if (clear) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            ready <= 1'b0;
        end else begin
            if (doPush) begin
                wrPtr <= bump(wrPtr);
            end
            if (doPop) begin
                rdPtr <= bump(rdPtr);
            end
            count <= next_count;
            // size register caps the usable depth
            ready <= (8'(next_count) < limit) && (next_count < CW'(DEPTH));
        end
    end

    // storage carries no reset; contents are dead until count says otherwise
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= din;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module hfp_host_ports import hfp_pkg::*; #(
    parameter int RXD_DEPTH = `HFP_RXD_DEPTH,
    parameter int TXD_DEPTH = `HFP_TXD_DEPTH,
    parameter int RXS_DEPTH = `HFP_RXS_DEPTH,
    parameter int TXS_DEPTH = `HFP_TXS_DEPTH,
    // arbitrary identification value
    parameter logic [31:0] ID_VALUE = 32'h0000_5a5a
) (
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic softReset,
    // host bus
    input wire logic bus16,
    input wire hfp_req_t hostReq,
    output logic [31:0] hostRdata,
    output logic hostRvalid,
    // datapath side
    input wire hfp_beat_t rxStsIn,
    output logic rxStsReady,
    input wire hfp_beat_t rxDataIn,
    output logic rxDataReady,
    input wire hfp_beat_t txStsIn,
    output logic txStsReady,
    output hfp_beat_t txDataOut,
    input wire logic txDataReady,
    // status events and controls
    input wire logic evtW1c,
    input wire logic evtRc,
    input wire logic linkLevelPin,
    input wire logic actionDone,
    output logic actionStart,
    output logic [7:0] keepOut,
    output logic [31:0] cmdData,
    output logic cmdStrobe
);
    localparam int RDW = $clog2(RXD_DEPTH + 1);
    localparam int TDW = $clog2(TXD_DEPTH + 1);
    localparam int RSW = $clog2(RXS_DEPTH + 1);
    localparam int TSW = $clog2(TXS_DEPTH + 1);

    logic [7:0] regAddr;
    logic hiHalf;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic rdRxd;
    logic wrTxd;
    logic rdAttr;
    logic wrAttr;
    logic popRxs;
    logic popRxd;
    logic popTxs;
    logic popTxd;
    logic pushTxd;
    logic [31:0] txdDin;
    logic [31:0] rxsHead;
    logic [31:0] rxdHead;
    logic [31:0] txsHead;
    logic [31:0] txdHead;
    logic [RSW-1:0] rxsCount;
    logic [RDW-1:0] rxdCount;
    logic [TSW-1:0] txsCount;
    logic [TDW-1:0] txdCount;
    logic txdReady;
    logic rxHalf;
    logic txHalf;
    logic [15:0] txLow;
    logic [2:0] lvlSync;
    logic lvl;
    logic w1cBit;
    logic rcBit;
    logic llBit;
    logic lhBit;
    logic scBit;
    hfp_sc_t scState;
    logic [7:0] keepField;
    logic [23:0] sizeCfg;
    logic [31:0] attrWord;
    logic [31:0] rword;
    logic rhi;
    logic [31:0] next_rdata;

    function automatic logic inAlias(input logic [7:0] a, input logic [7:0] base);
        return (a & `HFP_ALIAS_MASK) == base;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // address decode and 16-bit lane steering
    assign regAddr = {hostReq.addr[7:2], 2'b00};
    assign hiHalf = bus16 && hostReq.addr[1];
    assign wmask = !bus16 ? 32'hffffffff : (hostReq.addr[1] ? 32'hffff0000 : 32'h0000ffff);
    assign wval = bus16 ? {hostReq.wdata[15:0], hostReq.wdata[15:0]} : hostReq.wdata;
    assign rdRxd = hostReq.rd && inAlias(hostReq.addr, `HFP_RXD_BASE);
    assign wrTxd = hostReq.wr && inAlias(hostReq.addr, `HFP_TXD_BASE);
    assign rdAttr = hostReq.rd && (regAddr == `HFP_ATTR_REG) && !hiHalf;
    assign wrAttr = hostReq.wr && (regAddr == `HFP_ATTR_REG);
    // a 16-bit host pops only after taking the upper half
    assign popRxs = hostReq.rd && (regAddr == `HFP_RXS_PORT) && (!bus16 || hostReq.addr[1]);
    assign popTxs = hostReq.rd && (regAddr == `HFP_TXS_PORT) && (!bus16 || hostReq.addr[1]);
    assign popRxd = rdRxd && (!bus16 || rxHalf);
    assign pushTxd = wrTxd && (!bus16 || txHalf);
    assign txdDin = bus16 ? {hostReq.wdata[15:0], txLow} : hostReq.wdata;
    assign popTxd = (!txDataOut.valid || txDataReady) && (txdCount != '0);
    assign scBit = (scState == SC_BUSY);
    assign attrWord = {16'h0000, keepField, 3'b000, scBit, lhBit, llBit, rcBit, w1cBit};

    ////////////////////////////////////////////////////////////////////////////
    // the four FIFOs; a software reset empties them all
    hfp_fifo #(.DW(32), .DEPTH(RXS_DEPTH)) rxsFifo (
        .clk(clk), .reset(reset), .clear(softReset),
        .push(rxStsIn.valid), .din(rxStsIn.data), .ready(rxStsReady),
        .pop(popRxs), .limit(sizeCfg[23:16]), .head(rxsHead), .count(rxsCount)
    );
    hfp_fifo #(.DW(32), .DEPTH(RXD_DEPTH)) rxdFifo (
        .clk(clk), .reset(reset), .clear(softReset),
        .push(rxDataIn.valid), .din(rxDataIn.data), .ready(rxDataReady),
        .pop(popRxd), .limit(sizeCfg[7:0]), .head(rxdHead), .count(rxdCount)
    );
    hfp_fifo #(.DW(32), .DEPTH(TXS_DEPTH)) txsFifo (
        .clk(clk), .reset(reset), .clear(softReset),
        .push(txStsIn.valid), .din(txStsIn.data), .ready(txStsReady),
        .pop(popTxs), .limit(8'(TXS_DEPTH)), .head(txsHead), .count(txsCount)
    );
    hfp_fifo #(.DW(32), .DEPTH(TXD_DEPTH)) txdFifo (
        .clk(clk), .reset(reset), .clear(softReset),
        .push(pushTxd), .din(txdDin), .ready(txdReady),
        .pop(popTxd), .limit(sizeCfg[15:8]), .head(txdHead), .count(txdCount)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read data mux
    always_comb begin
        rword = 32'h00000000;
        rhi = hiHalf;
        if (inAlias(hostReq.addr, `HFP_RXD_BASE)) begin
            rword = (rxdCount != '0) ? rxdHead : 32'h00000000;
            rhi = bus16 && rxHalf;
        end else if (regAddr == `HFP_RXS_PORT || regAddr == `HFP_RXS_PEEK) begin
            rword = (rxsCount != '0) ? rxsHead : 32'h00000000;
        end else if (regAddr == `HFP_TXS_PORT || regAddr == `HFP_TXS_PEEK) begin
            rword = (txsCount != '0) ? txsHead : 32'h00000000;
        end else if (regAddr == `HFP_ATTR_REG) begin
            rword = attrWord;
        end else if (regAddr == `HFP_ID_REG) begin
            rword = ID_VALUE;
        end else if (regAddr == `HFP_SIZE_REG) begin
            rword = {8'h00, sizeCfg};
        end else begin
            // write-only ports and unmapped locations read as zero
            rword = 32'h00000000;
        end
        next_rdata = bus16 ? {16'h0000, rhi ? rword[31:16] : rword[15:0]} : rword;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hostRdata <= 32'h00000000;
            hostRvalid <= 1'b0;
        end else begin
            hostRvalid <= hostReq.rd;
            if (hostReq.rd) begin
                hostRdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 16-bit half tracking for the data ports
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxHalf <= 1'b0;
            txHalf <= 1'b0;
            txLow <= 16'h0000;
        end else if (softReset || !bus16) begin
            rxHalf <= 1'b0;
            txHalf <= 1'b0;
        end else begin
            if (rdRxd && rxdCount != '0) begin
                rxHalf <= !rxHalf;
            end
            if (wrTxd) begin
                txHalf <= !txHalf;
                if (!txHalf) begin
                    txLow <= hostReq.wdata[15:0];
                end
            end
        end
    end

    // registered drain stage so the datapath sees flop outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txDataOut <= '0;
        end else if (softReset) begin
            txDataOut <= '0;
        end else if (!txDataOut.valid || txDataReady) begin
            txDataOut.valid <= (txdCount != '0);
            txDataOut.data <= txdHead;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // reset to the pin's idle high level so no false low follows reset
            lvlSync <= 3'b111;
            lvl <= 1'b1;
        end else begin
            lvlSync <= {lvlSync[1:0], linkLevelPin};
            if (lvlSync[1] == lvlSync[2]) begin
                lvl <= lvlSync[2];
            end
        end
    end

    // status bits; a hardware set always beats a host clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            w1cBit <= 1'b0;
            rcBit <= 1'b0;
            llBit <= 1'b1;
            lhBit <= 1'b0;
        end else if (softReset) begin
            w1cBit <= 1'b0;
            rcBit <= 1'b0;
            llBit <= 1'b1;
            lhBit <= 1'b0;
        end else begin
            w1cBit <= evtW1c || (w1cBit && !(wrAttr && wmask[`HFP_BIT_W1C] && wval[`HFP_BIT_W1C]));
            rcBit <= evtRc || (rcBit && !rdAttr);
            llBit <= lvl && (llBit || rdAttr);
            lhBit <= lvl || (lhBit && !rdAttr);
        end
    end

    // self-clearing start bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scState <= SC_IDLE;
            actionStart <= 1'b0;
        end else if (softReset) begin
            scState <= SC_IDLE;
            actionStart <= 1'b0;
        end else begin
            actionStart <= 1'b0;
            case (scState)
                SC_IDLE: begin
                    if (wrAttr && wmask[`HFP_BIT_SC] && wval[`HFP_BIT_SC]) begin
                        scState <= SC_BUSY;
                        actionStart <= 1'b1;
                    end
                end
                SC_BUSY: begin
                    if (actionDone) begin
                        scState <= SC_IDLE;
                    end
                end
                default: scState <= SC_IDLE;
            endcase
        end
    end

    // field that only a full reset returns to default
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            keepField <= `HFP_KEEP_RESET;
        end else if (wrAttr) begin
            keepField <= (keepField & ~wmask[15:8]) | (wval[15:8] & wmask[15:8]);
        end
    end
    assign keepOut = keepField;

    // size and command registers; the ID register has no write path at all
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sizeCfg <= `HFP_SIZE_RESET;
            cmdData <= 32'h00000000;
            cmdStrobe <= 1'b0;
        end else if (softReset) begin
            sizeCfg <= `HFP_SIZE_RESET;
            cmdData <= 32'h00000000;
            cmdStrobe <= 1'b0;
        end else begin
            cmdStrobe <= hostReq.wr && (regAddr == `HFP_CMD_REG);
            if (hostReq.wr && regAddr == `HFP_SIZE_REG) begin
                sizeCfg <= (sizeCfg & ~wmask[23:0]) | (wval[23:0] & wmask[23:0]);
            end
            if (hostReq.wr && regAddr == `HFP_CMD_REG) begin
                cmdData <= (cmdData & ~wmask) | (wval & wmask);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence scKick;
        wrAttr && wmask[`HFP_BIT_SC] && wval[`HFP_BIT_SC] && scState == SC_IDLE && !softReset;
    endsequence
    sequence scDone;
        actionDone && scBit && !softReset;
    endsequence

    ro_write_a: assert property (
        hostReq.wr && regAddr == `HFP_ID_REG && !softReset
        |=> $stable(sizeCfg) && $stable(keepField) && $stable(cmdData))
        else $error("read-only write changed state");
    wo_read_a: assert property (
        hostReq.rd && (regAddr == `HFP_CMD_REG || inAlias(hostReq.addr, `HFP_TXD_BASE))
        |=> hostRvalid && hostRdata == 32'h00000000)
        else $error("write-only read not zero");
    w1c_clear_a: assert property (
        wrAttr && !softReset |=> w1cBit == ($past(evtW1c)
        || ($past(w1cBit) && !($past(wmask[0]) && $past(wval[0])))))
        else $error("write-one-clear wrong");
    rc_clear_a: assert property (
        rdAttr && !softReset |=> rcBit == $past(evtRc))
        else $error("clear-on-read wrong");
    latch_hold_a: assert property (
        lhBit && !rdAttr && !softReset |=> lhBit)
        else $error("latch-high lost before read");
    keep_soft_a: assert property (
        softReset && !wrAttr |=> keepField == $past(keepField))
        else $error("kept field lost on soft reset");
    soft_default_a: assert property (
        softReset |=> sizeCfg == `HFP_SIZE_RESET && rxsCount == '0 && !w1cBit && !scBit)
        else $error("soft reset defaults wrong");
    rxs_pop_a: assert property (
        popRxs && rxsCount != '0 && !softReset
        |=> rxsCount == $past(rxsCount) + $past(rxStsIn.valid && rxStsReady) - 1)
        else $error("rx status pop wrong");
    rxs_peek_a: assert property (
        hostReq.rd && regAddr == `HFP_RXS_PEEK && !bus16 && rxsCount != '0 && !softReset
        |=> hostRdata == $past(rxsHead) && rxsCount >= $past(rxsCount))
        else $error("rx status peek wrong");
    rxd_pop_a: assert property (
        rdRxd && !bus16 && rxdCount != '0 && !softReset
        |=> hostRdata == $past(rxdHead)
        && rxdCount == $past(rxdCount) + $past(rxDataIn.valid && rxDataReady) - 1)
        else $error("rx data alias pop wrong");
    txs_pop_a: assert property (
        popTxs && !bus16 && txsCount != '0 && !softReset
        |=> hostRdata == $past(txsHead)
        && txsCount == $past(txsCount) + $past(txStsIn.valid && txStsReady) - 1)
        else $error("tx status pop wrong");
    txs_peek_a: assert property (
        hostReq.rd && regAddr == `HFP_TXS_PEEK && !softReset |=> txsCount >= $past(txsCount))
        else $error("tx status peek popped");
    txd_push_a: assert property (
        wrTxd && !bus16 && txdReady && !softReset
        |=> txdCount == $past(txdCount) + 1 - $past(popTxd))
        else $error("tx data write not appended");
    sc_start_a: assert property (
        scKick |=> actionStart && scBit)
        else $error("self-clear start missing");
    sc_clear_a: assert property (
        scDone |=> !scBit && !actionStart)
        else $error("self-clear bit stuck");
endmodule
`default_nettype wire

// ---- hdl/hfp_params.svh ----
`ifndef HFP_PARAMS_SVH
`define HFP_PARAMS_SVH
// host port byte offsets
`define HFP_RXD_BASE 8'h00
`define HFP_TXD_BASE 8'h20
`define HFP_ALIAS_MASK 8'he0
`define HFP_RXS_PORT 8'h40
`define HFP_RXS_PEEK 8'h44
`define HFP_TXS_PORT 8'h48
`define HFP_TXS_PEEK 8'h4c
`define HFP_ATTR_REG 8'h50
`define HFP_ID_REG 8'h54
`define HFP_CMD_REG 8'h58
`define HFP_SIZE_REG 8'h5c
// attribute register bit positions
`define HFP_BIT_W1C 0
`define HFP_BIT_RC 1
`define HFP_BIT_LL 2
`define HFP_BIT_LH 3
`define HFP_BIT_SC 4
`define HFP_KEEP_LSB 8
// reset values and depths
`define HFP_KEEP_RESET 8'h00
`define HFP_RXD_DEPTH 16
`define HFP_TXD_DEPTH 16
`define HFP_RXS_DEPTH 8
`define HFP_TXS_DEPTH 8
`define HFP_SIZE_RESET 24'h081010
`endif

// ---- hdl/hfp_pkg.sv ----
package hfp_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hfp_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } hfp_beat_t;
    typedef enum logic [1:0] {
        SC_IDLE = 2'b01,
        SC_BUSY = 2'b10
    } hfp_sc_t;
endpackage

// ---- sim/hfp_dp_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hfp_dp_model import hfp_pkg::*; (
    // clock
    input wire logic clk,
    // streams into the block
    output hfp_beat_t rxSts,
    output hfp_beat_t rxData,
    output hfp_beat_t txSts,
    input wire logic rxStsReady,
    input wire logic rxDataReady,
    input wire logic txStsReady,
    // transmit data out of the block
    input wire hfp_beat_t txDataOut,
    input wire logic stall,
    output logic txDataReady
);
    logic [31:0] got[$];

    initial begin
        rxSts = '0;
        rxData = '0;
        txSts = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel 0 rx status, 1 rx data, 2 tx status; idle data is inverted so it never looks valid
    task automatic send(input int ch, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        #1;
        case (ch)
            0: rxSts = '{valid: 1'b1, data: d};
            1: rxData = '{valid: 1'b1, data: d};
            default: txSts = '{valid: 1'b1, data: d};
        endcase
        do begin
            @(posedge clk);
            rdy = (ch == 0) ? rxStsReady : (ch == 1) ? rxDataReady : txStsReady;
        end while (rdy !== 1'b1);
        #1;
        case (ch)
            0: rxSts = '{valid: 1'b0, data: ~d};
            1: rxData = '{valid: 1'b0, data: ~d};
            default: txSts = '{valid: 1'b0, data: ~d};
        endcase
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // sink may stall to prove the block holds its word
    assign txDataReady = !stall;

    always @(posedge clk) begin
        if (txDataOut.valid === 1'b1 && txDataReady) begin
            got.push_back(txDataOut.data);
        end
    end
endmodule
`default_nettype wire

// ---- sim/host_fifo_ports_and_csr_access_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_fifo_ports_and_csr_access_test import hfp_pkg::*; ;
    // arbitrary identification value
    localparam logic [31:0] IDV = 32'h0000_3c3c;
    logic clk = 1'b0, reset = 1'b1, softReset = 1'b0, bus16 = 1'b0, stall = 1'b0;
    logic evtW1c = 1'b0, evtRc = 1'b0, linkLevelPin = 1'b1, actionDone = 1'b0;
    hfp_req_t hostReq = '0;
    hfp_beat_t rxStsIn, rxDataIn, txStsIn, txDataOut;
    logic [31:0] hostRdata, cmdData, lastCmd, d;
    logic hostRvalid, rxStsReady, rxDataReady, txStsReady, txDataReady;
    logic actionStart, cmdStrobe;
    logic [7:0] keepOut;
    int failCount = 0, totalChecks = 0, starts = 0, strobes = 0, s0;

    hfp_host_ports #(.ID_VALUE(IDV)) u_hfp_host_ports (.clk(clk), .reset(reset),
        .softReset(softReset), .bus16(bus16), .hostReq(hostReq), .hostRdata(hostRdata),
        .hostRvalid(hostRvalid), .rxStsIn(rxStsIn), .rxStsReady(rxStsReady),
        .rxDataIn(rxDataIn), .rxDataReady(rxDataReady), .txStsIn(txStsIn),
        .txStsReady(txStsReady), .txDataOut(txDataOut), .txDataReady(txDataReady),
        .evtW1c(evtW1c), .evtRc(evtRc), .linkLevelPin(linkLevelPin),
        .actionDone(actionDone), .actionStart(actionStart), .keepOut(keepOut),
        .cmdData(cmdData), .cmdStrobe(cmdStrobe));

    hfp_dp_model u_hfp_dp_model (.clk(clk), .rxSts(rxStsIn), .rxData(rxDataIn),
        .txSts(txStsIn), .rxStsReady(rxStsReady), .rxDataReady(rxDataReady),
        .txStsReady(txStsReady), .txDataOut(txDataOut), .stall(stall),
        .txDataReady(txDataReady));

    always #50 clk = ~clk;

    // pulses are counted so a late or doubled pulse is caught
    always @(posedge clk) begin
        if (actionStart === 1'b1) starts <= starts + 1;
        if (cmdStrobe === 1'b1) begin
            strobes <= strobes + 1;
            lastCmd <= cmdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        #1;
        hostReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clk);
        #1;
        hostReq.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        #1;
        hostReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(posedge clk);
        #1;
        hostReq.rd = 1'b0;
        chk({31'h0, hostRvalid}, 32'h1);
        v = hostRdata;
    endtask

    // 0 raises the write-one-clear event, 1 the clear-on-read event, 2 ends the action
    task automatic pulse(input int s);
        @(posedge clk);
        #1;
        {actionDone, evtRc, evtW1c} = 3'b001 << s;
        @(posedge clk);
        #1;
        {actionDone, evtRc, evtW1c} = 3'b000;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_status;
        logic [7:0] b;
        for (int i = 0; i < 2; i++) begin
            b = 8'h40 + 8'(8 * i);
            u_hfp_dp_model.send(2 * i, 32'h1100_0001 + i);
            u_hfp_dp_model.send(2 * i, 32'h2200_0002 + i);
            rd(b + 8'h04, d);
            chk(d, 32'h1100_0001 + i);
            rd(b + 8'h04, d);
            chk(d, 32'h1100_0001 + i);
            rd(b, d);
            chk(d, 32'h1100_0001 + i);
            rd(b + 8'h04, d);
            chk(d, 32'h2200_0002 + i);
            rd(b, d);
            chk(d, 32'h2200_0002 + i);
            rd(b, d);
            chk(d, 32'h0);
        end
        $display("status fifo test done");
    endtask

    task automatic t_rxdata;
        for (int i = 0; i < 8; i++) u_hfp_dp_model.send(1, 32'hd0d0_0000 + i);
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), d);
            chk(d, 32'hd0d0_0000 + i);
        end
        bus16 = 1'b1;
        u_hfp_dp_model.send(1, 32'h1234_5678);
        rd(8'h1c, d);
        chk({16'h0, d[15:0]}, 32'h5678);
        rd(8'h1e, d);
        chk({16'h0, d[15:0]}, 32'h1234);
        bus16 = 1'b0;
        rd(8'h08, d);
        chk(d, 32'h0);
        $display("rx data test done");
    endtask

    task automatic t_txdata;
        settle(1);
        stall = 1'b1;
        for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'hc0de_0000 + i);
        settle(4);
        chk(32'(u_hfp_dp_model.got.size()), 32'h0);
        stall = 1'b0;
        settle(24);
        bus16 = 1'b1;
        wr(8'h24, 32'h0000_beef);
        wr(8'h26, 32'h0000_cafe);
        bus16 = 1'b0;
        settle(6);
        chk(32'(u_hfp_dp_model.got.size()), 32'h9);
        for (int i = 0; i < 8; i++) chk(u_hfp_dp_model.got[i], 32'hc0de_0000 + i);
        chk(u_hfp_dp_model.got[8], 32'hcafe_beef);
        rd(8'h20, d);
        chk(d, 32'h0);
        $display("tx data test done");
    endtask

    task automatic t_access;
        wr(8'h54, ~IDV);
        rd(8'h54, d);
        chk(d, IDV);
        wr(8'h58, 32'h1357_9bdf);
        settle(2);
        chk(32'(strobes), 32'h1);
        chk(lastCmd, 32'h1357_9bdf);
        rd(8'h58, d);
        chk(d, 32'h0);
        pulse(0);
        rd(8'h50, d);
        chk({31'h0, d[0]}, 32'h1);
        wr(8'h50, 32'h0);
        rd(8'h50, d);
        chk({31'h0, d[0]}, 32'h1);
        wr(8'h50, 32'h1);
        rd(8'h50, d);
        chk({31'h0, d[0]}, 32'h0);
        pulse(1);
        rd(8'h50, d);
        chk({31'h0, d[1]}, 32'h1);
        rd(8'h50, d);
        chk({31'h0, d[1]}, 32'h0);
        linkLevelPin = 1'b0;
        settle(6);
        linkLevelPin = 1'b1;
        settle(6);
        rd(8'h50, d);
        chk({31'h0, d[2]}, 32'h0);
        rd(8'h50, d);
        chk({31'h0, d[2]}, 32'h1);
        s0 = starts;
        wr(8'h50, 32'h10);
        settle(3);
        chk(32'(starts - s0), 32'h1);
        rd(8'h50, d);
        chk({31'h0, d[4]}, 32'h1);
        pulse(2);
        settle(1);
        rd(8'h50, d);
        chk({31'h0, d[4]}, 32'h0);
        $display("access attribute test done");
    endtask

    task automatic t_soft;
        rd(8'h5c, d);
        chk(d, 32'h0008_1010);
        wr(8'h50, 32'h0000_a500);
        wr(8'h5c, 32'h0003_0405);
        rd(8'h5c, d);
        chk(d, 32'h0003_0405);
        chk({24'h0, keepOut}, 32'ha5);
        u_hfp_dp_model.send(1, 32'h7777_0001);
        settle(1);
        softReset = 1'b1;
        settle(1);
        softReset = 1'b0;
        settle(2);
        chk({24'h0, keepOut}, 32'ha5);
        rd(8'h5c, d);
        chk(d, 32'h0008_1010);
        rd(8'h00, d);
        chk(d, 32'h0);
        rd(8'h50, d);
        chk({16'h0, d[15:0]}, 32'ha50c);
        $display("soft reset test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task testDone;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the tests need well under 3000 cycles
    initial begin
        #2000000;
        failCount++;
        testDone;
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        settle(2);
        t_soft;
        t_status;
        t_rxdata;
        t_txdata;
        t_access;
        testDone;
    end
endmodule
`default_nettype wire
